/* File: src/lcd_waveform_consts.svh */
`ifndef LCD_WAVEFORM_CONSTS_SVH
`define LCD_WAVEFORM_CONSTS_SVH
// Register byte offsets
`define OFF_CTRL0 8'h00
`define OFF_PIN_EN 8'h04
`define OFF_BP_EN 8'h08
`define OFF_CTRL1 8'h0C
`define OFF_IRQ_ST 8'h10
`define OFF_IRQ_MSK 8'h14
`define OFF_STATUS 8'h18
// Control zero fields
`define BIT_WAVE_EN 7
`define BIT_CLK_SRC 6
`define PRESC_HI 5
`define PRESC_LO 3
`define DUTY_HI 2
`define DUTY_LO 0
// Control one fields
`define BIT_FRAME_IEN 7
`define BIT_PUMP_SEL 0
// Interrupt status fields
`define BIT_FRAME_EV 0
// Reset values
`define RST_CTRL0 8'h03
`define RST_CTRL1 8'h00
`define RST_PIN_EN 8'h00
`define RST_BP_EN 8'h00
`define RST_IRQ_MSK 8'h00
// Frame divider figures and pin count
`define FRAME_MULT_SHIFT 3
`define PRESC_BASE 4'h4
`define Y_TABLE {5'h10, 5'h08, 5'h05, 5'h04, 5'h03, 5'h03, 5'h02, 5'h02}
`define PIN_COUNT 8
`endif

/* File: src/lcd_waveform_pkg.sv */
`include "lcd_waveform_consts.svh"
package lcd_waveform_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN = 2'b10
	} run_state_t;

	typedef logic [11:0] phase_len_t;

	// Ticks in one backplane phase: 8 x (4 + prescaler) x Y
	function automatic phase_len_t phase_len(input logic [2:0] presc, input logic [2:0] duty);
		logic [39:0] ytab;
		logic [4:0] y;
		logic [8:0] prod;
		ytab = `Y_TABLE;
		y = ytab[{duty, 2'b00} + {3'b000, duty} +: 5];
		prod = 9'({1'b0, `PRESC_BASE} + {2'b00, presc}) * 9'(y);
		phase_len = 12'({prod, 3'b000});
	endfunction : phase_len
endpackage : lcd_waveform_pkg

/* File: src/lcd_waveform_control.sv */
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ns
// Notes on behaviour
// - Enable clear: all pins off, driver off, waveform clocks stopped.
// - While disabled, the top bias rail is tied to the main supply.
// - While enabled, enabled pins drive waveforms; backplanes follow the count.
// - Setting enable also switches on the selected bias source.
// - Clock source bit 6: zero external oscillator, one alternate clock.
// - Frame = glass clock / ((N+1) x 8 x (4+prescaler) x Y).
// - Y is 2,2,3,3,4,5,8,16 for backplane codes 0 to 7.
// - Backplane code N gives N+1 backplanes; reset code is 011.
// - With frame irq enable set, each frame start sets the frame flag; irq_out rises only while its mask bit is set.
////////////////////////////////////////////////////////////////////////////////
`include "lcd_waveform_consts.svh"
module lcd_waveform_control
	import lcd_waveform_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic external_osc_clock_in,
	input wire logic alt_clock_in,
	output logic [`PIN_COUNT-1:0] lcd_pin_out,
	output logic [`PIN_COUNT-1:0] lcd_pin_oe_out,
	output logic bias_enable_out,
	output logic bias_pump_sel_out,
	output logic top_bias_tie_out,
	output logic glass_clock_run_out,
	output logic irq_out
);

	typedef struct packed {
		run_state_t state;
		logic [7:0] ctrl0;
		logic [7:0] ctrl1;
		logic [7:0] pin_enable_bank;
		logic [7:0] bp_enable;
		logic [7:0] irq_status;
		logic [7:0] irq_mask;
		logic [31:0] prdata;
		logic [2:0] osc_sync;
		logic [2:0] alt_sync;
		logic [11:0] tick_cnt;
		logic [2:0] bp_phase;
		logic polarity;
		logic [`PIN_COUNT-1:0] pin_val;
		logic [`PIN_COUNT-1:0] pin_oe;
		logic [15:0] frame_ticks;
		logic seen_frame;
	} ctl_state_t;

	localparam ctl_state_t RST_STATE = '{
		state: ST_IDLE,
		ctrl0: `RST_CTRL0,
		ctrl1: `RST_CTRL1,
		pin_enable_bank: `RST_PIN_EN,
		bp_enable: `RST_BP_EN,
		irq_status: 8'h00,
		irq_mask: `RST_IRQ_MSK,
		prdata: 32'h0000_0000,
		osc_sync: 3'h0,
		alt_sync: 3'h0,
		tick_cnt: 12'h000,
		bp_phase: 3'h0,
		polarity: 1'b0,
		pin_val: '0,
		pin_oe: '0,
		frame_ticks: 16'h0000,
		seen_frame: 1'b0
	};

	ctl_state_t state_reg;
	ctl_state_t state_next;

	logic waveform_enable;
	logic clk_src_alt;
	logic [2:0] frame_prescaler;
	logic [2:0] bp_code;
	logic glass_tick;
	logic running;
	logic phase_end;
	logic frame_start;
	logic bus_setup;
	logic bus_access;
	logic addr_hit;
	logic [7:0] wbyte;
	logic [11:0] cur_phase_len;
	logic [`PIN_COUNT-1:0] pin_val_calc;
	logic [`PIN_COUNT-1:0] pin_oe_calc;

	assign waveform_enable = state_reg.ctrl0[`BIT_WAVE_EN];
	assign clk_src_alt = state_reg.ctrl0[`BIT_CLK_SRC];
	assign frame_prescaler = state_reg.ctrl0[`PRESC_HI:`PRESC_LO];
	assign bp_code = state_reg.ctrl0[`DUTY_HI:`DUTY_LO];
	assign running = (state_reg.state == ST_RUN);
	assign cur_phase_len = phase_len(frame_prescaler, bp_code);
	assign bus_setup = psel_in && !penable_in;
	assign bus_access = psel_in && penable_in;
	assign wbyte = pwdata_in[7:0];

	// Offset decode, used only by the error answer
	function automatic logic mapped(input logic [7:0] a);
		case (a)
			`OFF_CTRL0, `OFF_PIN_EN, `OFF_BP_EN, `OFF_CTRL1,
			`OFF_IRQ_ST, `OFF_IRQ_MSK, `OFF_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction : mapped

	assign addr_hit = mapped(paddr_in);

	////////////////////////////////////////////////////////////////////////////////
	// Glass clock: both sources are foreign, so only the synchronised copies feed logic
	always_comb begin
		if (clk_src_alt) begin
			glass_tick = state_reg.alt_sync[1] && !state_reg.alt_sync[2];
		end else begin
			glass_tick = state_reg.osc_sync[1] && !state_reg.osc_sync[2];
		end
	end

	assign phase_end = running && glass_tick && (state_reg.tick_cnt == cur_phase_len - 12'h001);
	assign frame_start = running && glass_tick && (state_reg.tick_cnt == 12'h000)
		&& (state_reg.bp_phase == 3'h0);

	////////////////////////////////////////////////////////////////////////////////
	// Pin waveforms; segment data storage is outside this block
	generate
		for (genvar i = 0; i < `PIN_COUNT; i++) begin : g_pin
			always_comb begin
				pin_oe_calc[i] = running && state_reg.pin_enable_bank[i];
				if (state_reg.bp_enable[i]) begin
					// A backplane above the selected count stays idle at frame polarity
					pin_val_calc[i] = state_reg.polarity
						^ ((state_reg.bp_phase == 3'(i)) && (3'(i) <= bp_code));
				end else begin
					pin_val_calc[i] = !state_reg.polarity;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		state_next.osc_sync = {state_reg.osc_sync[1:0], external_osc_clock_in};
		state_next.alt_sync = {state_reg.alt_sync[1:0], alt_clock_in};
		state_next.pin_val = pin_val_calc;
		state_next.pin_oe = pin_oe_calc;

		case (state_reg.state)
			ST_IDLE: begin
				state_next.tick_cnt = 12'h000;
				state_next.bp_phase = 3'h0;
				state_next.polarity = 1'b0;
				if (waveform_enable) begin
					state_next.state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!waveform_enable) begin
					state_next.state = ST_IDLE;
					state_next.tick_cnt = 12'h000;
					state_next.bp_phase = 3'h0;
					state_next.polarity = 1'b0;
				end else if (phase_end) begin
					state_next.tick_cnt = 12'h000;
					if (state_reg.bp_phase >= bp_code) begin
						state_next.bp_phase = 3'h0;
						// Toggling each frame keeps the glass free of DC
						state_next.polarity = !state_reg.polarity;
					end else begin
						state_next.bp_phase = state_reg.bp_phase + 3'h1;
					end
				end else if (glass_tick) begin
					state_next.tick_cnt = state_reg.tick_cnt + 12'h001;
				end
			end
			default: begin
				state_next.state = ST_IDLE;
			end
		endcase

		// Read data is captured in the setup cycle, so it is a flop at the access edge
		if (bus_setup && !pwrite_in) begin
			case (paddr_in)
				`OFF_CTRL0: state_next.prdata = {24'h000000, state_reg.ctrl0};
				`OFF_PIN_EN: state_next.prdata = {24'h000000, state_reg.pin_enable_bank};
				`OFF_BP_EN: state_next.prdata = {24'h000000, state_reg.bp_enable};
				`OFF_CTRL1: state_next.prdata = {24'h000000, state_reg.ctrl1};
				`OFF_IRQ_ST: state_next.prdata = {24'h000000, state_reg.irq_status};
				`OFF_IRQ_MSK: state_next.prdata = {24'h000000, state_reg.irq_mask};
				`OFF_STATUS: state_next.prdata = {20'h00000, running, state_reg.polarity,
					1'b0, state_reg.bp_phase, state_reg.tick_cnt[5:0]};
				default: state_next.prdata = 32'h0000_0000;
			endcase
		end

		// Writes land only at the access edge; no write guard on the divider fields,
		// software keeps them still while enabled
		if (bus_access && pwrite_in) begin
			case (paddr_in)
				`OFF_CTRL0: state_next.ctrl0 = wbyte;
				`OFF_PIN_EN: state_next.pin_enable_bank = wbyte;
				`OFF_BP_EN: state_next.bp_enable = wbyte;
				`OFF_CTRL1: state_next.ctrl1 = wbyte;
				`OFF_IRQ_MSK: state_next.irq_mask = wbyte;
				`OFF_IRQ_ST: state_next.irq_status = state_reg.irq_status & ~wbyte;
				default: state_next.ctrl0 = state_reg.ctrl0;
			endcase
		end

		// Set after the clear so a frame start in the clearing cycle is kept
		if (frame_start && state_reg.ctrl1[`BIT_FRAME_IEN]) begin
			state_next.irq_status[`BIT_FRAME_EV] = 1'b1;
		end

		// Glass ticks since the last frame start, for the frame length check
		if (!running) begin
			state_next.frame_ticks = 16'h0000;
			state_next.seen_frame = 1'b0;
		end else if (frame_start) begin
			state_next.frame_ticks = 16'h0001;
			state_next.seen_frame = 1'b1;
		end else if (glass_tick) begin
			state_next.frame_ticks = state_reg.frame_ticks + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg <= RST_STATE;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign prdata_out = state_reg.prdata;
	assign pready_out = 1'b1;
	assign pslverr_out = bus_access && !addr_hit;
	assign lcd_pin_out = state_reg.pin_val;
	assign lcd_pin_oe_out = state_reg.pin_oe;
	assign bias_enable_out = running;
	assign bias_pump_sel_out = state_reg.ctrl1[`BIT_PUMP_SEL];
	assign top_bias_tie_out = !running;
	assign glass_clock_run_out = running;
	assign irq_out = |(state_reg.irq_status & state_reg.irq_mask);

	////////////////////////////////////////////////////////////////////////////////
	property p_disabled_quiet;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		!waveform_enable ##1 !waveform_enable |=> (lcd_pin_oe_out == '0) && !glass_clock_run_out;
	endproperty
	a_disabled_quiet: assert property (p_disabled_quiet)
		else $error("pins or clocks active while disabled");

	property p_tie_rail;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		top_bias_tie_out == !bias_enable_out;
	endproperty
	a_tie_rail: assert property (p_tie_rail)
		else $error("top bias rail tie does not mirror enable");

	property p_pin_enable;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		running && $stable(state_reg.pin_enable_bank) |=> lcd_pin_oe_out == $past(state_reg.pin_enable_bank);
	endproperty
	a_pin_enable: assert property (p_pin_enable)
		else $error("enabled pins not driven");

	property p_bias_on;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		$rose(waveform_enable) |=> bias_enable_out;
	endproperty
	a_bias_on: assert property (p_bias_on)
		else $error("bias source not switched on one cycle after enable");

	property p_clk_src;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		running && waveform_enable && !clk_src_alt
			&& state_reg.osc_sync[1] && !state_reg.osc_sync[2]
			&& !phase_end |=> state_reg.tick_cnt == $past(state_reg.tick_cnt) + 12'h001;
	endproperty
	a_clk_src: assert property (p_clk_src)
		else $error("oscillator edge not counted");

	property p_frame_len;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		frame_start && state_reg.seen_frame |->
			state_reg.frame_ticks == 16'(({1'b0, bp_code} + 4'h1) * cur_phase_len);
	endproperty
	a_frame_len: assert property (p_frame_len)
		else $error("frame length differs from divider formula");

	property p_y_factor;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		bp_code == 3'h6 && frame_prescaler == 3'h0 |-> cur_phase_len == 12'h100;
	endproperty
	a_y_factor: assert property (p_y_factor)
		else $error("duty factor for code 6 is not 8");

	property p_phase_range;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		running |-> state_reg.bp_phase <= bp_code;
	endproperty
	a_phase_range: assert property (p_phase_range)
		else $error("backplane phase beyond selected count");

	property p_frame_irq;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		frame_start && state_reg.ctrl1[`BIT_FRAME_IEN] |=> state_reg.irq_status[`BIT_FRAME_EV];
	endproperty
	a_frame_irq: assert property (p_frame_irq)
		else $error("frame start did not set the frame flag");

	property p_no_irq;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		!state_reg.irq_status[`BIT_FRAME_EV] && !state_reg.ctrl1[`BIT_FRAME_IEN]
			|=> !state_reg.irq_status[`BIT_FRAME_EV];
	endproperty
	a_no_irq: assert property (p_no_irq)
		else $error("frame flag set with frame irq disabled");

	property p_hold_zero;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		!running |-> state_reg.tick_cnt == 12'h000 && state_reg.bp_phase == 3'h0;
	endproperty
	a_hold_zero: assert property (p_hold_zero)
		else $error("counters not held while disabled");

	c_enable_run: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
		$rose(running));
	c_full_frame: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
		frame_start && state_reg.seen_frame);
	c_irq: cover property (@(posedge ref_clk_in) disable iff (!rstn_in)
		$rose(irq_out));

endmodule : lcd_waveform_control

/* File: tb/lcd_glass_model.sv */
`timescale 1ns/1ns
module lcd_glass_model (
	input wire logic ref_clk_in,
	input wire logic use_alt_in,
	input wire logic run_in,
	output logic osc_out,
	output logic alt_out,
	output int ticks_out
);
	int div;
	initial begin
		osc_out = 1'b0;
		alt_out = 1'b0;
		div = 0;
		ticks_out = 0;
	end
	// Half period of 3 clocks keeps the rate under clk/4 yet keeps frames short
	// Only the selected source moves, so a wrong source select starves the frame
	always @(posedge ref_clk_in) begin
		div <= (div + 1) % 3;
		if (run_in && div == 2) begin
			if (use_alt_in)
				alt_out <= !alt_out;
			else
				osc_out <= !osc_out;
			if ((use_alt_in ? alt_out : osc_out) == 1'b0)
				ticks_out <= ticks_out + 1;
		end
	end
endmodule : lcd_glass_model

/* File: tb/lcd_waveform_control_tb_top.sv */
`timescale 1ns/1ns
module lcd_waveform_control_tb_top;
	logic clk, rstn, psel, pen, pwr, alt_sel, run, perr_s;
	logic [7:0] pa, oe, pin;
	logic [31:0] pwd, prd, rd, w;
	logic prdy, perr, osc, altc, bias, pump, tie, grun, irq;
	int err_total, checked, seed, ticks, d, p, t0;
	int ytab[8] = '{2, 2, 3, 3, 4, 5, 8, 16};
	logic [31:0] shadow[8];
	////////////////////////////////////////////////////////////////////////////////
	lcd_waveform_control u_dut (.ref_clk_in(clk), .rstn_in(rstn), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
		.prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
		.external_osc_clock_in(osc), .alt_clock_in(altc), .lcd_pin_out(pin),
		.lcd_pin_oe_out(oe), .bias_enable_out(bias), .bias_pump_sel_out(pump),
		.top_bias_tie_out(tie), .glass_clock_run_out(grun), .irq_out(irq));
	lcd_glass_model u_glass (.ref_clk_in(clk), .use_alt_in(alt_sel), .run_in(run),
		.osc_out(osc), .alt_out(altc), .ticks_out(ticks));
	////////////////////////////////////////////////////////////////////////////////
	task final_report;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		pa <= a;
		pwd <= wd;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1 && n < 50);
		rd = prd;
		perr_s = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n >= 50) begin
			err_total++;
			final_report;
		end
		// Bench model of the plain read/write registers
		if (wr && a < 8'h10)
			shadow[a[4:2]] = wd & 32'hFF;
		if (wr && a == 8'h14)
			shadow[5] = wd & 32'hFF;
	endtask : apb
	task rd_chk(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
		chk("readback", shadow[a[4:2]], rd);
	endtask : rd_chk
	task wirq;
		int n;
		// Let a flag clear land before looking again
		repeat (2) @(posedge clk);
		n = 0;
		while (irq !== 1'b1 && n < 40000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 40000) begin
			err_total++;
			final_report;
		end
	endtask : wirq
	task frame(input int e, input int base);
		// The first counted edge after enable opens the first frame
		wirq;
		apb(1'b1, 8'h10, 32'h1);
		wirq;
		chk("frame_ticks", e, ticks - base - 1);
	endtask : frame
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		seed = 31;
		{psel, pen, pwr, rstn, alt_sel, run} = 6'h00;
		pa = 8'h00;
		pwd = 32'h0;
		err_total = 0;
		checked = 0;
		foreach (shadow[i]) shadow[i] = 32'h0;
		shadow[0] = 32'h03;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		chk("oe_rst", 8'h00, oe);
		chk("tie_rst", 1, tie);
		chk("run_rst", 0, grun);
		rd_chk(8'h00);
		apb(1'b0, 8'h1C, 32'h0);
		chk("pslverr", 1, perr_s);
		chk("unmapped", 0, rd);
		$display("test reset done");
		run <= 1'b1;
		apb(1'b1, 8'h0C, 32'h01);
		apb(1'b1, 8'h14, 32'h01);
		apb(1'b1, 8'h00, 32'h80);
		repeat (800) @(posedge clk);
		apb(1'b0, 8'h10, 32'h0);
		chk("irq_st_off", 0, rd);
		chk("pump", 1, pump);
		apb(1'b1, 8'h14, 32'h0);
		apb(1'b1, 8'h0C, 32'h80);
		repeat (800) @(posedge clk);
		apb(1'b0, 8'h10, 32'h0);
		chk("irq_st_on", 1, rd);
		chk("irq_masked", 0, irq);
		apb(1'b1, 8'h14, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq_unmasked", 1, irq);
		apb(1'b1, 8'h00, 32'h0);
		run <= 1'b0;
		$display("test irq done");
		for (d = 0; d < 8; d++) begin
			// Long duties keep the prescaler at 0 so the run stays short
			p = (d < 4) ? ($random(seed) & 7) : 0;
			w = {25'h0, 1'(d % 2), 3'(p), 3'(d)};
			alt_sel <= w[6];
			apb(1'b1, 8'h04, $random(seed) & 32'hFF);
			apb(1'b1, 8'h08, $random(seed) & 32'hFF);
			apb(1'b1, 8'h00, w);
			rd_chk(8'h04);
			// Drop a flag left from the last run; nothing sets it while disabled
			apb(1'b1, 8'h10, 32'h1);
			apb(1'b1, 8'h00, w | 32'h80);
			t0 = ticks;
			run <= 1'b1;
			repeat (3) @(posedge clk);
			chk("oe_on", shadow[1], oe);
			chk("bias_on", 1, bias);
			chk("tie_off", 0, tie);
			chk("run_on", 1, grun);
			chk("pin_on", (~shadow[2] | 32'h1) & 32'hFF, pin);
			rd_chk(8'h00);
			frame((d + 1) * 8 * (4 + p) * ytab[d], t0);
			apb(1'b1, 8'h00, w);
			run <= 1'b0;
			repeat (3) @(posedge clk);
			chk("oe_off", 0, oe);
			chk("bias_off", 0, bias);
			chk("tie_on", 1, tie);
			apb(1'b0, 8'h18, 32'h0);
			chk("status_idle", 0, rd);
			$display("test frame code %0d done", d);
		end
		final_report;
	end
endmodule : lcd_waveform_control_tb_top
